// File: dv/asf_host_model.sv
`timescale 1ns/100ps
// Host end of the link: offers request frames and collects the replies.
module asf_host_model (
	input wire logic clk_sys_in, // System clock.
	output logic [7:0] rx_data_out, // Character to the device.
	output logic rx_valid_out, // Character offered.
	input wire logic rx_ready_in, // Device is listening.
	input wire logic [7:0] tx_data_in, // Reply character.
	input wire logic tx_valid_in, // Reply character valid.
	input wire logic stall_in, // High: hold off replies.
	output logic tx_ready_out // Host takes reply characters.
);
	logic [7:0] got_q[$]; // Reply characters in arrival order.
	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
	end
	// Each character is held until taken; released data shows the inverse, never the old value.
	task automatic send(input logic [7:0] q[$]);
		@(posedge clk_sys_in);
		foreach (q[i]) begin
			rx_data_out <= q[i];
			rx_valid_out <= 1'b1;
			do @(negedge clk_sys_in); while (rx_ready_in !== 1'b1);
			@(posedge clk_sys_in);
		end
		rx_valid_out <= 1'b0;
		rx_data_out <= ~q[q.size() - 1];
	endtask : send
	// Old values are sampled at the edge, so no race with the device's registers.
	always @(posedge clk_sys_in) begin
		if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
		tx_ready_out <= !stall_in;
	end
endmodule : asf_host_model

// File: dv/test_ascii_station_link_framer.sv
`timescale 1ns/100ps
module test_ascii_station_link_framer;
	localparam int STEP = 8; // Short delay step keeps the run brief.
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] rx_data, tx_data, req_instr, csum;
	logic rx_valid, rx_ready, tx_valid, tx_ready, req_valid, req_write;
	logic [23:0] req_data, rsp_data = 24'h0;
	logic [4:0] station = 5'h01;
	logic wait_en = 1'b0, term_en = 1'b0, rsp_valid = 1'b0, rsp_err = 1'b0, stall = 1'b0;
	logic [3:0] steps = 4'h2, rsp_code = 4'h0, wt = 4'h3;
	logic [1:0] fmt = 2'h0;
	logic [7:0] req_q[$], exp_q[$];
	int mismatches = 0, tests_run = 0, cycles = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	asf_framer #(.WAIT_STEP_CYCLES(STEP)) asf_framer_inst (.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
		.rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
		.tx_ready_in(tx_ready), .station_id_in(station), .wait_char_en_in(wait_en),
		.reply_delay_steps_in(steps), .line_terminator_select_in(term_en),
		.data_fmt_in(fmt), .req_valid_out(req_valid), .req_write_out(req_write),
		.req_instr_out(req_instr), .req_data_out(req_data), .rsp_valid_in(rsp_valid),
		.rsp_error_in(rsp_err), .rsp_code_in(rsp_code), .rsp_data_in(rsp_data));
	asf_host_model asf_host_model_inst (.clk_sys_in(clk_sys_in), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_data_in(tx_data),
		.tx_valid_in(tx_valid), .stall_in(stall), .tx_ready_out(tx_ready));
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction : hx
	function automatic int dl();
		return (fmt == 2'h1) ? 2 : (fmt == 2'h2) ? 6 : 4;
	endfunction : dl
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Appends to the request (e low) or the expected reply, keeping the running sum.
	task automatic put(input logic e, input logic [7:0] c);
		if (e) exp_q.push_back(c);
		else req_q.push_back(c);
		csum += c;
	endtask : put
	task automatic put_hex(input logic e, input logic [23:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) put(e, hx(v[i*4 +: 4]));
	endtask : put_hex
	task automatic term(input logic e);
		if (term_en) begin
			put(e, 8'h0d);
			put(e, 8'h0a);
		end
	endtask : term
	task automatic cfg(input logic [4:0] st, input logic w, t, input logic [1:0] f);
		@(posedge clk_sys_in);
		station <= st;
		wait_en <= w;
		term_en <= t;
		fmt <= f;
		@(posedge clk_sys_in);
	endtask : cfg
	// A nonzero bias spoils the sum check on purpose.
	task automatic request(input logic [4:0] st, input logic [7:0] ins, input logic [23:0] d,
		input logic [7:0] bias);
		req_q = {};
		exp_q = {};
		put(1'b0, 8'h05);
		csum = 8'h00;
		put_hex(1'b0, {19'h0, st}, 2);
		put_hex(1'b0, {16'h0, ins}, 2);
		if (wait_en) put(1'b0, hx(wt));
		if (ins[7]) put_hex(1'b0, d, dl());
		put_hex(1'b0, {16'h0, csum + bias}, 2);
		term(1'b0);
		asf_host_model_inst.send(req_q);
	endtask : request
	task automatic confirm(input logic [7:0] c);
		req_q = {};
		put(1'b0, c);
		put_hex(1'b0, 24'h1f, 2);
		term(1'b0);
		asf_host_model_inst.send(req_q);
	endtask : confirm
	// Plays the application, then times the reply against the expected delay.
	task automatic answer(input logic [7:0] ins, input logic [23:0] d, input logic err,
		input logic [3:0] code, input logic [23:0] rd, input int n_steps);
		int n;
		n = 0;
		do @(negedge clk_sys_in); while (req_valid !== 1'b1 && ++n < 300);
		check("req_valid", req_valid, 1'b1);
		check("req_write", req_write, ins[7]);
		check("req_instr", req_instr, ins);
		check("req_data", req_data, d);
		@(posedge clk_sys_in);
		rsp_valid <= 1'b1;
		rsp_err <= err;
		rsp_code <= code;
		rsp_data <= rd;
		@(posedge clk_sys_in);
		rsp_valid <= 1'b0;
		n = 0;
		while (tx_valid !== 1'b1 && n < 500) begin
			@(negedge clk_sys_in);
			n++;
		end
		check("delay", n + 1 >= n_steps * STEP && n <= n_steps * STEP + 6, 1'b1);
	endtask : answer
	task automatic collect(input string what);
		int n;
		n = 0;
		while (asf_host_model_inst.got_q.size() < exp_q.size() && n++ < 600) @(posedge clk_sys_in);
		repeat (3 * STEP) @(posedge clk_sys_in);
		check(what, asf_host_model_inst.got_q.size(), exp_q.size());
		foreach (exp_q[i]) if (i < asf_host_model_inst.got_q.size())
			check(what, asf_host_model_inst.got_q[i], exp_q[i]);
		asf_host_model_inst.got_q = {};
	endtask : collect
	task automatic s_write_std();
		request(5'h01, 8'hed, 24'h1770, 8'h00);
		answer(8'hed, 24'h1770, 1'b0, 4'h0, 24'h0, 2);
		put(1'b1, 8'h06);
		put_hex(1'b1, 24'h01, 2);
		collect("ack reply");
	endtask : s_write_std
	task automatic s_read_crlf();
		cfg(5'h1f, 1'b1, 1'b1, 2'h1);
		request(5'h1f, 8'h7b, 24'h0, 8'h00);
		answer(8'h7b, 24'h0, 1'b0, 4'h0, 24'h0000a5, 3);
		put(1'b1, 8'h02);
		csum = 8'h00;
		put_hex(1'b1, 24'h1f, 2);
		put_hex(1'b1, 24'ha5, dl());
		put(1'b1, 8'h03);
		put_hex(1'b1, {16'h0, csum}, 2);
		term(1'b1);
		collect("read reply");
		confirm(8'h15);
		collect("read resend");
		confirm(8'h06);
		exp_q = {};
		collect("after confirm");
		req_q = {8'h05, 8'h31, 8'h46, 8'h37, 8'h42, 8'h33, 8'h30, 8'h30, 8'h0d, 8'h0d};
		asf_host_model_inst.send(req_q);
		exp_q = {8'h15, 8'h31, 8'h46, 8'h33, 8'h0d, 8'h0a};
		collect("proto nak");
	endtask : s_read_crlf
	task automatic s_long_stall();
		cfg(5'h01, 1'b0, 1'b0, 2'h2);
		stall <= 1'b1;
		request(5'h01, 8'hf3, 24'h12abcf, 8'h00);
		answer(8'hf3, 24'h12abcf, 1'b1, 4'ha, 24'h0, 2);
		repeat (20) @(posedge clk_sys_in);
		check("stalled", asf_host_model_inst.got_q.size(), 0);
		stall <= 1'b0;
		put(1'b1, 8'h15);
		put_hex(1'b1, 24'h01, 2);
		put(1'b1, hx(4'ha));
		collect("app nak");
	endtask : s_long_stall
	task automatic s_bad_sum_and_other();
		request(5'h01, 8'hf3, 24'h000400, 8'h01);
		put(1'b1, 8'h15);
		put_hex(1'b1, 24'h01, 2);
		put(1'b1, hx(4'h2));
		collect("sum nak");
		request(5'h02, 8'h7b, 24'h0, 8'h00);
		collect("other station");
		req_q = {8'h05, 8'h30, 8'h31, 8'h37, 8'h47, 8'h30, 8'h30};
		asf_host_model_inst.send(req_q);
		exp_q = {8'h15, 8'h30, 8'h31, 8'h37};
		collect("char nak");
	endtask : s_bad_sum_and_other
	task automatic report_and_stop();
		$display("Checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	// Reset is held two cycles; a hang is cut short by the cycle ceiling.
	initial begin
		repeat (2) @(posedge clk_sys_in);
		check("tx idle in reset", tx_valid, 1'b0);
		resetn_in <= 1'b1;
		s_write_std();
		s_read_crlf();
		s_long_stall();
		s_bad_sum_and_other();
		report_and_stop();
	end
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
endmodule : test_ascii_station_link_framer

// File: hw/asf_fifo.sv
`timescale 1ns/100ps
// Transmit queue; the head word is held in an output register.
module asf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys_in, // System clock.
	input wire logic resetn_in, // Async reset, active low.
	asf_stream_if.snk in_s, // Fill side.
	asf_stream_if.src out_s // Drain side.
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH]; // Storage array.
	logic [AW-1:0] wr_q; // Write pointer.
	logic [AW-1:0] rd_q; // Read pointer.
	logic [AW:0] cnt_q; // Words held in the array.
	logic [W-1:0] out_q; // Registered head word.
	logic out_v_q; // Head word valid.
	logic push;
	logic load;
	// Full stalls the framer, so back-pressure reaches the reply builder.
	assign in_s.ready = (cnt_q != (AW + 1)'(DEPTH));
	assign push = in_s.valid & in_s.ready;
	// Refill the head register whenever it is empty or being taken.
	assign load = (cnt_q != '0) & (~out_v_q | out_s.ready);
	assign out_s.valid = out_v_q;
	assign out_s.data = out_q;
	// Array write; no reset needed for data storage.
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_q[wr_q] <= in_s.data;
		end
	end
	// Pointers and occupancy.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(load);
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
		end
	end
	// Output register.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			out_q <= '0;
			out_v_q <= 1'b0;
		end else if (load) begin
			out_q <= mem_q[rd_q];
			out_v_q <= 1'b1;
		end else if (out_s.ready) begin
			out_v_q <= 1'b0;
		end
	end
endmodule : asf_fifo

// File: hw/asf_framer.sv
// How it works
// - STX 02, ETX 03, ENQ 05 opens requests.
// - ACK is 06, NAK is 15.
// - Station 00..1F; answer only own station.
// - Good write answered ACK plus station.
// - Bad request answered NAK, station, error code.
// - Good read: STX, station, data, ETX, sum.
// - Wait digit times 10 ms, up to 150.
// - Wait character absent unless setting is 9999.
// - Delay runs from request end to reply.
// - Sum is low byte, two hex characters.
// - CR LF terminators selected by configuration.
// - Instruction code selects operation and data meaning.
// - Never transmit without an addressed request.
`timescale 1ns/100ps
`include "asf_regs.svh"
module asf_framer #(
	parameter int unsigned WAIT_STEP_CYCLES = `ASF_WAIT_STEP_CYC // Cycles per delay step.
) (
	input wire logic clk_sys_in, // System clock, 50 MHz.
	input wire logic resetn_in, // Async reset, active low.
	input wire logic [7:0] rx_data_in, // Received character.
	input wire logic rx_valid_in, // Received character valid.
	output logic rx_ready_out, // Framer takes characters.
	output logic [7:0] tx_data_out, // Character to send.
	output logic tx_valid_out, // Send character valid.
	input wire logic tx_ready_in, // Link takes the character.
	input wire logic [4:0] station_id_in, // Own station number.
	input wire logic wait_char_en_in, // High: reply_delay_setting is 9999.
	input wire logic [3:0] reply_delay_steps_in, // Delay steps without wait char.
	input wire logic line_terminator_select_in, // High: CR LF used.
	input wire logic [1:0] data_fmt_in, // 0 standard, 1 short, 2 long.
	output logic req_valid_out, // Pulse: request to application.
	output logic req_write_out, // Request is a write.
	output logic [7:0] req_instr_out, // Instruction code.
	output logic [23:0] req_data_out, // Write data, right aligned.
	input wire logic rsp_valid_in, // Pulse: application answers.
	input wire logic rsp_error_in, // Application rejects request.
	input wire logic [3:0] rsp_code_in, // Error code for rejection.
	input wire logic [23:0] rsp_data_in // Read data, right aligned.
);
	asf_pkg::asf_state_e state_q; // Sequencer state.
	asf_pkg::asf_kind_e kind_q; // Reply kind.
	logic [3:0] pos_q, tpos_q, wdig_q, code_q; // Indices, wait digit and error code.
	logic [7:0] station_q, instr_q; // Received station number and instruction code.
	logic [23:0] data_q, rdata_q; // Received write data and read data to send.
	logic [7:0] rsum_q, csum_q; // Received sum check and sum computed over the frame.
	logic char_err_q, proto_err_q, conf_nak_q, conf_bad_q; // Frame and confirmation flags.
	logic rsp_got_q, req_valid_q; // Reply content known and request pulse.
	logic [7:0] tsum_q, tx_ch; // Reply sum and the reply character at tpos_q.
	logic acc, is_enq, addressed; // Character taken, it is ENQ, station matches.
	logic tmr_done, push_fire; // Delay elapsed and reply character queued.
	logic [4:0] hv; // Decoded hex digit.
	logic [2:0] dl; // Data length of format.
	logic [3:0] dstart, sstart, rx_last, conf_last, tx_last; // Field starts and frame ends.
	asf_stream_if #(.W(8)) push_if ();
	asf_stream_if #(.W(8)) pop_if ();

	// Characters are taken only while listening, never while replying.
	assign rx_ready_out = state_q inside {asf_pkg::ST_IDLE, asf_pkg::ST_REQ, asf_pkg::ST_CONF};
	assign acc = rx_valid_in & rx_ready_out;
	assign is_enq = (rx_data_in == `ASF_CH_ENQ);
	assign hv = asf_pkg::asf_hex_val(rx_data_in);
	assign dl = asf_pkg::asf_data_len(data_fmt_in);
	// The wait character slot exists only in the 9999 setting.
	assign dstart = `ASF_POS_WAIT + {3'h0, wait_char_en_in};
	// Only writes carry data; the instruction decides which it is.
	assign sstart = dstart + (instr_q[`ASF_WRITE_BIT] ? {1'b0, dl} : 4'h0);
	assign rx_last = sstart + 4'h1 + (line_terminator_select_in ? 4'h2 : 4'h0);
	assign conf_last = 4'h2 + (line_terminator_select_in ? 4'h2 : 4'h0);
	// Stations above 1F never match since the top bits must be zero.
	assign addressed = (station_q == {3'h0, station_id_in});

	// Request and confirmation parsing.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pos_q <= 4'h0;
			station_q <= 8'h00;
			instr_q <= 8'h00;
			wdig_q <= 4'h0;
			data_q <= 24'h000000;
			rsum_q <= 8'h00;
			csum_q <= 8'h00;
			char_err_q <= 1'b0;
			proto_err_q <= 1'b0;
			conf_nak_q <= 1'b0;
			conf_bad_q <= 1'b0;
		end else if (acc && is_enq && state_q != asf_pkg::ST_CONF || acc && is_enq && pos_q == 4'h0) begin
			// An ENQ restarts a request, also mid-frame, except after the first character of a confirmation.
			pos_q <= 4'h0;
			csum_q <= 8'h00;
			char_err_q <= 1'b0;
			proto_err_q <= 1'b0;
			instr_q <= 8'h00;
			data_q <= 24'h000000;
		end else if (acc && state_q == asf_pkg::ST_REQ) begin
			pos_q <= pos_q + 4'h1;
			if (pos_q < sstart) begin
				csum_q <= csum_q + rx_data_in;
				char_err_q <= char_err_q | hv[4];
			end
			if (pos_q < `ASF_POS_INSTR) begin
				station_q <= {station_q[3:0], hv[3:0]};
			end else if (pos_q < `ASF_POS_WAIT) begin
				instr_q <= {instr_q[3:0], hv[3:0]};
			end else if (wait_char_en_in && pos_q == `ASF_POS_WAIT) begin
				wdig_q <= hv[3:0];
			end else if (pos_q < sstart) begin
				data_q <= {data_q[19:0], hv[3:0]};
			end else if (pos_q < sstart + 4'h2) begin
				rsum_q <= {rsum_q[3:0], hv[3:0]};
				char_err_q <= char_err_q | hv[4];
			end else if (pos_q == sstart + 4'h2) begin
				proto_err_q <= proto_err_q | (rx_data_in != `ASF_CH_CR);
			end else begin
				proto_err_q <= proto_err_q | (rx_data_in != `ASF_CH_LF);
			end
		end else if (acc && state_q == asf_pkg::ST_CONF) begin
			pos_q <= pos_q + 4'h1;
			if (pos_q == 4'h0) begin
				conf_nak_q <= (rx_data_in == `ASF_CH_NAK);
				conf_bad_q <= (rx_data_in != `ASF_CH_NAK) && (rx_data_in != `ASF_CH_ACK);
			end else if (pos_q < 4'h3) begin
				station_q <= {station_q[3:0], hv[3:0]};
			end
		end else if (state_q == asf_pkg::ST_SEND) begin
			// Ready to count the host's confirmation from zero.
			pos_q <= 4'h0;
		end
	end

	// Sequencer.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= asf_pkg::ST_IDLE;
		end else begin
			case (state_q)
				asf_pkg::ST_IDLE: begin
					if (acc && is_enq) begin
						state_q <= asf_pkg::ST_REQ;
					end
				end
				asf_pkg::ST_REQ: begin
					if (acc && !is_enq && pos_q == rx_last) begin
						state_q <= asf_pkg::ST_CHECK;
					end
				end
				asf_pkg::ST_CHECK: begin
					// Frames for other stations are dropped without a word.
					state_q <= addressed ? asf_pkg::ST_WAIT : asf_pkg::ST_IDLE;
				end
				asf_pkg::ST_WAIT: begin
					if (rsp_got_q && tmr_done) begin
						state_q <= asf_pkg::ST_SEND;
					end
				end
				asf_pkg::ST_SEND: begin
					if (push_fire && tpos_q == tx_last) begin
						state_q <= (kind_q == asf_pkg::KIND_READ) ? asf_pkg::ST_CONF
							: asf_pkg::ST_IDLE;
					end
				end
				asf_pkg::ST_CONF: begin
					if (acc && is_enq && pos_q == 4'h0) begin
						state_q <= asf_pkg::ST_REQ;
					end else if (acc && pos_q == conf_last) begin
						state_q <= asf_pkg::ST_CONFCHK;
					end
				end
				default: begin
					// A NAK from the host for us repeats the read reply.
					state_q <= (conf_nak_q && !conf_bad_q && addressed) ? asf_pkg::ST_SEND
						: asf_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Reply content: own errors first, otherwise the application's answer.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			kind_q <= asf_pkg::KIND_ACK;
			code_q <= 4'h0;
			rdata_q <= 24'h000000;
			rsp_got_q <= 1'b0;
			req_valid_q <= 1'b0;
			req_write_out <= 1'b0;
			req_instr_out <= 8'h00;
			req_data_out <= 24'h000000;
		end else begin
			req_valid_q <= 1'b0;
			if (state_q == asf_pkg::ST_CHECK && addressed) begin
				if (char_err_q || proto_err_q || csum_q != rsum_q) begin
					kind_q <= asf_pkg::KIND_NAK;
					rsp_got_q <= 1'b1;
					// A bad character makes the sum meaningless, so it wins.
					code_q <= char_err_q ? `ASF_ERR_CHAR : proto_err_q ? `ASF_ERR_PROTO
						: `ASF_ERR_SUM;
				end else begin
					rsp_got_q <= 1'b0;
					req_valid_q <= 1'b1;
					req_write_out <= instr_q[`ASF_WRITE_BIT];
					req_instr_out <= instr_q;
					req_data_out <= data_q;
				end
			end else if (state_q == asf_pkg::ST_WAIT && rsp_valid_in && !rsp_got_q) begin
				rsp_got_q <= 1'b1;
				code_q <= rsp_code_in;
				rdata_q <= rsp_data_in;
				if (rsp_error_in) begin
					kind_q <= asf_pkg::KIND_NAK;
				end else if (req_write_out) begin
					kind_q <= asf_pkg::KIND_ACK;
				end else begin
					kind_q <= asf_pkg::KIND_READ;
				end
			end
		end
	end
	assign req_valid_out = req_valid_q;

	// Delay from the end of the request; the digit counts 10 ms steps.
	asf_wait_timer #(.STEP_CYCLES(WAIT_STEP_CYCLES)) u_timer (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.start_in(state_q == asf_pkg::ST_CHECK && addressed),
		.steps_in(wait_char_en_in ? wdig_q : reply_delay_steps_in),
		.done_out(tmr_done)
	);

	// Reply length: body, sum for reads, optional terminator.
	always_comb begin
		case (kind_q)
			asf_pkg::KIND_ACK: tx_last = 4'h2;
			asf_pkg::KIND_NAK: tx_last = 4'h3;
			default: tx_last = 4'h5 + {1'b0, dl};
		endcase
		tx_last = tx_last + (line_terminator_select_in ? 4'h2 : 4'h0);
	end

	// Character generator for the reply at tpos_q.
	always_comb begin
		logic [3:0] blen;
		logic [3:0] k;
		logic [4:0] sh;
		blen = line_terminator_select_in ? tx_last - 4'h1 : 4'hf; // No tail without CR LF.
		k = tpos_q - 4'h3;
		sh = {2'h0, dl - 3'h1 - k[2:0]} << 2;
		if (tpos_q == 4'h0) begin
			tx_ch = (kind_q == asf_pkg::KIND_READ) ? `ASF_CH_STX
				: (kind_q == asf_pkg::KIND_ACK) ? `ASF_CH_ACK : `ASF_CH_NAK;
		end else if (tpos_q == 4'h1) begin
			tx_ch = asf_pkg::asf_hex_chr({3'h0, station_id_in[4]});
		end else if (tpos_q == 4'h2) begin
			tx_ch = asf_pkg::asf_hex_chr(station_id_in[3:0]);
		end else if (tpos_q >= blen) begin
			tx_ch = (tpos_q == blen) ? `ASF_CH_CR : `ASF_CH_LF;
		end else if (kind_q == asf_pkg::KIND_NAK) begin
			tx_ch = asf_pkg::asf_hex_chr(code_q);
		end else if (k < {1'b0, dl}) begin
			tx_ch = asf_pkg::asf_hex_chr(4'(rdata_q >> sh));
		end else if (k == {1'b0, dl}) begin
			tx_ch = `ASF_CH_ETX;
		end else if (k == {1'b0, dl} + 4'h1) begin
			tx_ch = asf_pkg::asf_hex_chr(tsum_q[7:4]);
		end else begin
			tx_ch = asf_pkg::asf_hex_chr(tsum_q[3:0]);
		end
	end

	// Reply index and running sum; STX itself is left out of the sum.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tpos_q <= 4'h0;
			tsum_q <= 8'h00;
		end else if (state_q != asf_pkg::ST_SEND) begin
			tpos_q <= 4'h0;
			tsum_q <= 8'h00;
		end else if (push_fire) begin
			tpos_q <= tpos_q + 4'h1;
			if (tpos_q != 4'h0 && tpos_q < 4'h4 + {1'b0, dl}) begin
				tsum_q <= tsum_q + tx_ch;
			end
		end
	end

	// Queue towards the link; a full queue holds the generator.
	assign push_if.valid = (state_q == asf_pkg::ST_SEND);
	assign push_if.data = tx_ch;
	assign push_fire = push_if.valid & push_if.ready;
	assign pop_if.ready = tx_ready_in;
	assign tx_valid_out = pop_if.valid;
	assign tx_data_out = pop_if.data;
	asf_fifo #(.W(8), .DEPTH(`ASF_FIFO_DEPTH)) u_fifo (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.in_s(push_if),
		.out_s(pop_if)
	);

	// Checks.
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	read_start_a: assert property (push_fire && tpos_q == 4'h0 && kind_q == asf_pkg::KIND_READ
		|-> tx_ch == `ASF_CH_STX) else $error("read reply not opened by STX");
	ack_code_a: assert property (push_fire && tpos_q == 4'h0 && kind_q == asf_pkg::KIND_ACK
		|-> tx_ch == 8'h06) else $error("ACK not 06");
	station_drop_a: assert property (state_q == asf_pkg::ST_CHECK && !addressed
		|=> state_q == asf_pkg::ST_IDLE ##1 !push_if.valid) else $error("foreign frame answered");
	no_unsolicited_a: assert property ($rose(push_if.valid) |->
		$past(state_q) == asf_pkg::ST_WAIT || $past(state_q) == asf_pkg::ST_CONFCHK)
		else $error("reply without request");
	sum_err_a: assert property (state_q == asf_pkg::ST_CHECK && addressed && !char_err_q
		&& !proto_err_q && csum_q != rsum_q |=> kind_q == asf_pkg::KIND_NAK
		&& code_q == `ASF_ERR_SUM) else $error("sum error not reported");
	delay_hold_a: assert property (state_q == asf_pkg::ST_WAIT && !tmr_done
		|=> state_q != asf_pkg::ST_SEND) else $error("reply before delay");
	frame_end_a: assert property (acc && state_q == asf_pkg::ST_REQ && !is_enq
		&& pos_q == rx_last |=> state_q == asf_pkg::ST_CHECK ##1 state_q != asf_pkg::ST_REQ)
		else $error("frame end missed");
	term_cr_a: assert property (push_fire && line_terminator_select_in
		&& tpos_q == tx_last - 4'h1 |-> tx_ch == `ASF_CH_CR ##1 tx_ch == `ASF_CH_LF)
		else $error("terminator wrong");
	nak_code_a: assert property (push_fire && kind_q == asf_pkg::KIND_NAK && tpos_q == 4'h3
		|-> tx_ch == asf_pkg::asf_hex_chr(code_q)) else $error("NAK code wrong");
	ack_len_a: assert property (push_fire && kind_q == asf_pkg::KIND_ACK && tpos_q == tx_last
		|=> state_q == asf_pkg::ST_IDLE) else $error("ACK reply length");
	ack_c: cover property (push_fire && kind_q == asf_pkg::KIND_ACK && tpos_q == tx_last);
	nak_c: cover property (push_fire && kind_q == asf_pkg::KIND_NAK && tpos_q == tx_last);
	read_c: cover property (state_q == asf_pkg::ST_CONF);
	resend_c: cover property (state_q == asf_pkg::ST_CONFCHK ##1 state_q == asf_pkg::ST_SEND);
endmodule : asf_framer

// File: hw/asf_pkg.sv
package asf_pkg;
`include "asf_regs.svh"
	// Framer sequencing states.
	typedef enum logic [2:0] {
		ST_IDLE, ST_REQ, ST_CHECK, ST_WAIT, ST_SEND, ST_CONF, ST_CONFCHK
	} asf_state_e;
	// Kind of reply being sent.
	typedef enum logic [1:0] {KIND_ACK, KIND_NAK, KIND_READ} asf_kind_e;
	// Decode one ASCII hex digit; bit 4 flags a bad character.
	function automatic logic [4:0] asf_hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
		if (c >= 8'h41 && c <= 8'h46) return {1'b0, c[3:0] + 4'h9};
		return 5'h10;
	endfunction : asf_hex_val
	// Encode a nibble as an upper-case ASCII hex digit.
	function automatic logic [7:0] asf_hex_chr(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction : asf_hex_chr
	// Data field length for the selected format.
	function automatic logic [2:0] asf_data_len(input logic [1:0] f);
		case (f)
			2'h1: return `ASF_LEN_SHORT;
			2'h2: return `ASF_LEN_LONG;
			default: return `ASF_LEN_STD;
		endcase
	endfunction : asf_data_len
endpackage : asf_pkg

// File: hw/asf_regs.svh
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH
// Control characters on the link.
`define ASF_CH_STX 8'h02
`define ASF_CH_ETX 8'h03
`define ASF_CH_ENQ 8'h05
`define ASF_CH_ACK 8'h06
`define ASF_CH_LF 8'h0a
`define ASF_CH_CR 8'h0d
`define ASF_CH_NAK 8'h15
// Data field lengths in characters.
`define ASF_LEN_STD 3'h4
`define ASF_LEN_SHORT 3'h2
`define ASF_LEN_LONG 3'h6
// Field positions after the opening character.
`define ASF_POS_INSTR 4'h2
`define ASF_POS_WAIT 4'h4
// Instruction bit that marks a write request.
`define ASF_WRITE_BIT 7
// Error codes sent with a negative acknowledge.
`define ASF_ERR_SUM 4'h2
`define ASF_ERR_PROTO 4'h3
`define ASF_ERR_CHAR 4'h7
// Reply delay step and clock rate.
`define ASF_WAIT_STEP_MS 10
`define ASF_CLK_MHZ 50
`define ASF_WAIT_STEP_CYC (`ASF_WAIT_STEP_MS * 1000 * `ASF_CLK_MHZ)
`define ASF_FIFO_DEPTH 16
`endif

// File: hw/asf_stream_if.sv
`timescale 1ns/100ps
// Character stream with valid and ready between framer blocks.
interface asf_stream_if #(parameter int W = 8);
	logic [W-1:0] data; // Character.
	logic valid; // Source offers data.
	logic ready; // Sink takes data.
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface : asf_stream_if

// File: hw/asf_wait_timer.sv
`timescale 1ns/100ps
// Counts a number of fixed delay steps after a start pulse.
module asf_wait_timer #(
	parameter int unsigned STEP_CYCLES = 500000
) (
	input wire logic clk_sys_in, // System clock.
	input wire logic resetn_in, // Async reset, active low.
	input wire logic start_in, // Pulse: begin counting.
	input wire logic [3:0] steps_in, // Steps to wait.
	output logic done_out // High when no step remains.
);
	localparam int CW = $clog2(STEP_CYCLES + 1);
	logic [CW-1:0] cyc_q; // Cycles left in the current step.
	logic [3:0] steps_q; // Steps left.
	assign done_out = (steps_q == 4'h0);
	// A fresh start overrides any count still running.
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			steps_q <= 4'h0;
			cyc_q <= '0;
		end else if (start_in) begin
			steps_q <= steps_in;
			cyc_q <= CW'(STEP_CYCLES - 1);
		end else if (steps_q != 4'h0) begin
			if (cyc_q == '0) begin
				steps_q <= steps_q - 4'h1;
				cyc_q <= CW'(STEP_CYCLES - 1);
			end else begin
				cyc_q <= cyc_q - 1'b1;
			end
		end
	end
endmodule : asf_wait_timer
